// ### src/adc_ctl_map.vh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTL_MAP_VH
`define ADC_CTL_MAP_VH

`define ADDR_CTL_ZERO 12'h000
`define ADDR_CTL_ONE 12'h004
`define ADDR_CTL_TWO 12'h008

`define C0_START 0
`define C0_ENABLE 1
`define C0_MSC 7
`define C0_SHT 11:8
`define C0_WMASK 16'h0f82
`define C0_RESET 16'h0100

`define C1_TRIG 11:10
`define C1_PULSE 9
`define C1_INV 8
`define C1_DIV 7:5
`define C1_SSEL 4:3
`define C1_SEQ 2:1
`define C1_WMASK 16'h0ffe
`define C1_RESET 16'h0000

`define C2_RES 5:4
`define C2_WMASK 16'h033d
`define C2_RESET 16'h0010

`define TRIG_SOFT 2'h0
`define TRIG_T0 2'h1
`define TRIG_T1 2'h2
`define SSEL_MOD 2'h0
`define SSEL_AUX 2'h1

`define SEQ_SINGLE 2'h0
`define SEQ_SEQUENCE 2'h1
`define SEQ_REPEAT 2'h2

`define RES_8BIT 2'h0
`define RES_10BIT 2'h1
`define CONV_8BIT 11'h00a
`define CONV_10BIT 11'h00c
`define CONV_12BIT 11'h00e

`define SHT_0 11'h004
`define SHT_1 11'h008
`define SHT_2 11'h010
`define SHT_3 11'h020
`define SHT_4 11'h040
`define SHT_5 11'h060
`define SHT_6 11'h080
`define SHT_7 11'h0c0
`define SHT_8 11'h100
`define SHT_9 11'h180
`define SHT_10 11'h200
`define SHT_11 11'h300
`define SHT_MAX 11'h400

`endif

// ### src/adc_clock_divider.v
// Divides a stream of clock-enable ticks by a selectable factor of one to eight
`timescale 1ns/1ps
module adc_clock_divider #(
  parameter DIV_W = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Tick stream
  input wire tick_in,
  input wire [DIV_W-1:0] divide_sel,
  output reg tick_out
);

  reg [DIV_W-1:0] count;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= {DIV_W{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        // Compare with >= so a smaller divider takes effect at once
        if (count >= divide_sel) begin
          count <= {DIV_W{1'b0}};
          tick_out <= 1'b1;
        end else begin
          count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // adc_clock_divider

// ### src/adc_sample_clock_control.v
// Converter control: APB registers, trigger select, clock select and sequencing
`timescale 1ns/1ps
`include "adc_ctl_map.vh"

// Functional notes
// - Configuration fields of control one are written only while enable bit is 0.
// - Clearing enable then changing a field acts immediately, even mid-conversion.
// - Trigger field 11-10 picks software start bit or timer triggers 0, 1, 2.
// - Pulse-mode bit 9: sample signal from input directly or from sampling timer.
// - Bit 8 set inverts the selected sample input.
// - Clock field 4-3 picks module oscillator, auxiliary, or subsystem master clock.
// - Sequence field 2-1: single, sequence, repeat single, repeat sequence.
// - Read-only bit 0 shows busy while sampling, converting or in sequence.
// - Bits 15-12 of control one always read zero.
// - Pulse-mode sample period is 4 to 1024 converter clocks per sample time field.
// - With multi-sample and pulse mode set, only first edge starts; later conversions follow automatically.
module adc_sample_clock_control #(
  parameter DIV_W = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Timer triggers
  input wire timer_trigger_0,
  input wire timer_trigger_1,
  input wire timer_trigger_2,
  // Converter clock source ticks, one clk_sys cycle each
  input wire module_oscillator_clock,
  input wire aux_clock,
  input wire subsystem_master_clock,
  // Conversion core
  input wire last_channel,
  output reg sample_control_signal,
  output reg conversion_done,
  output reg converter_busy_flag
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SAMPLE = 4'b0010;
  localparam [3:0] ST_CONVERT = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;

  reg [15:0] control_reg_zero;
  reg [15:0] control_reg_one;
  reg [15:0] control_reg_two;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [10:0] timer;
  reg [10:0] next_timer;
  reg sample_q;
  reg edge_pend;
  reg start_taken;
  reg sel_tick;
  reg trig_raw;
  reg [10:0] sample_len;
  reg [10:0] conv_len;
  reg next_done;

  wire converter_clock;
  wire conversion_enable_bit;
  wire software_start_bit;
  wire multi_sample_bit;
  wire [3:0] sample_time_field;
  wire [1:0] trigger_source_sel;
  wire pulse_mode_sel;
  wire sample_input_invert;
  wire [2:0] clock_divider_field;
  wire [1:0] clock_source_sel;
  wire [1:0] sequence_mode_field;
  wire sample_input_signal;
  wire sample_rise;
  wire [2:0] wr_hit;
  wire [2:0] rd_hit;
  wire wr_access;
  wire [15:0] ctl_one_rd;

  // One-hot register hit for an address; zero when unmapped
  function [2:0] reg_hit;
    input [11:0] addr;
    begin
      case (addr)
        `ADDR_CTL_ZERO: reg_hit = 3'h1;
        `ADDR_CTL_ONE: reg_hit = 3'h2;
        `ADDR_CTL_TWO: reg_hit = 3'h4;
        default: reg_hit = 3'h0;
      endcase
    end
  endfunction

  function [10:0] sample_cycles;
    input [3:0] code;
    begin
      case (code)
        4'h0: sample_cycles = `SHT_0;
        4'h1: sample_cycles = `SHT_1;
        4'h2: sample_cycles = `SHT_2;
        4'h3: sample_cycles = `SHT_3;
        4'h4: sample_cycles = `SHT_4;
        4'h5: sample_cycles = `SHT_5;
        4'h6: sample_cycles = `SHT_6;
        4'h7: sample_cycles = `SHT_7;
        4'h8: sample_cycles = `SHT_8;
        4'h9: sample_cycles = `SHT_9;
        4'ha: sample_cycles = `SHT_10;
        4'hb: sample_cycles = `SHT_11;
        default: sample_cycles = `SHT_MAX;
      endcase
    end
  endfunction

  // fields feed the logic straight from the registers
  assign conversion_enable_bit = control_reg_zero[`C0_ENABLE];
  assign software_start_bit = control_reg_zero[`C0_START];
  assign multi_sample_bit = control_reg_zero[`C0_MSC];
  assign sample_time_field = control_reg_zero[`C0_SHT];
  assign trigger_source_sel = control_reg_one[`C1_TRIG];
  assign pulse_mode_sel = control_reg_one[`C1_PULSE];
  assign sample_input_invert = control_reg_one[`C1_INV];
  assign clock_divider_field = control_reg_one[`C1_DIV];
  assign clock_source_sel = control_reg_one[`C1_SSEL];
  assign sequence_mode_field = control_reg_one[`C1_SEQ];

  assign wr_access = psel & penable & pwrite;
  assign wr_hit = wr_access ? reg_hit(paddr) : 3'h0;
  assign rd_hit = reg_hit(paddr);
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & (rd_hit == 3'h0);
  // Busy replaces bit 0; reserved bits are masked off
  assign ctl_one_rd = (control_reg_one & `C1_WMASK) | {15'h0000, converter_busy_flag};

  always @* begin
    case (trigger_source_sel)
      `TRIG_SOFT: trig_raw = software_start_bit;
      `TRIG_T0: trig_raw = timer_trigger_0;
      `TRIG_T1: trig_raw = timer_trigger_1;
      default: trig_raw = timer_trigger_2;
    endcase
  end

  assign sample_input_signal = trig_raw ^ sample_input_invert;
  assign sample_rise = sample_input_signal & ~sample_q;

  always @* begin
    case (clock_source_sel)
      `SSEL_MOD: sel_tick = module_oscillator_clock;
      `SSEL_AUX: sel_tick = aux_clock;
      default: sel_tick = subsystem_master_clock;
    endcase
  end

  adc_clock_divider #(
    .DIV_W(DIV_W)
  ) u_divider (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick_in(sel_tick),
    .divide_sel(clock_divider_field),
    .tick_out(converter_clock)
  );

  always @* begin
    case (control_reg_two[`C2_RES])
      `RES_8BIT: conv_len = `CONV_8BIT;
      `RES_10BIT: conv_len = `CONV_10BIT;
      default: conv_len = `CONV_12BIT;
    endcase
    sample_len = sample_cycles(sample_time_field);
  end

  // sequencing advances only on converter clock ticks
  always @* begin
    next_state = state;
    next_timer = timer;
    next_done = 1'b0;
    start_taken = 1'b0;
    case (state)
      ST_IDLE, ST_WAIT: begin
        if (converter_clock) begin
          if (!conversion_enable_bit && state == ST_WAIT) begin
            next_state = ST_IDLE;
          end else if (conversion_enable_bit &&
                       (pulse_mode_sel ? edge_pend : sample_input_signal)) begin
            next_state = ST_SAMPLE;
            next_timer = sample_len;
            start_taken = 1'b1;
          end
        end
      end
      ST_SAMPLE: begin
        // timer or input ends the sample
        if (converter_clock) begin
          if (pulse_mode_sel ? (timer <= 11'h001) : !sample_input_signal) begin
            next_state = ST_CONVERT;
            next_timer = conv_len;
          end else if (pulse_mode_sel) begin
            next_timer = timer - 11'h001;
          end
        end
      end
      ST_CONVERT: begin
        if (converter_clock) begin
          if (timer <= 11'h001) begin
            next_done = 1'b1;
            // what follows a conversion depends on the mode
            if (sequence_mode_field == `SEQ_SINGLE ||
                (sequence_mode_field == `SEQ_SEQUENCE && last_channel) ||
                (sequence_mode_field[1] && !conversion_enable_bit &&
                 (sequence_mode_field == `SEQ_REPEAT || last_channel))) begin
              next_state = ST_IDLE;
            // automatic restart after the first edge
            end else if (multi_sample_bit && pulse_mode_sel) begin
              next_state = ST_SAMPLE;
              next_timer = sample_len;
            end else begin
              next_state = ST_WAIT;
            end
          end else begin
            next_timer = timer - 11'h001;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_timer = 11'h000;
      end
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      timer <= 11'h000;
      sample_q <= 1'b0;
      edge_pend <= 1'b0;
      sample_control_signal <= 1'b0;
      conversion_done <= 1'b0;
      converter_busy_flag <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      sample_q <= sample_input_signal;
      // A fresh edge in the consuming cycle is kept
      edge_pend <= sample_rise | (edge_pend & ~start_taken & conversion_enable_bit);
      // sample control from timer state or direct input
      sample_control_signal <= pulse_mode_sel ? (next_state == ST_SAMPLE) :
                               (sample_input_signal & (next_state == ST_SAMPLE));
      conversion_done <= next_done;
      // busy whenever the sequencer is not idle
      converter_busy_flag <= (next_state != ST_IDLE);
    end
  end

  // Register writes
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      control_reg_zero <= `C0_RESET;
      control_reg_one <= `C1_RESET;
      control_reg_two <= `C2_RESET;
    end else begin
      if (wr_hit[0]) begin
        if (!conversion_enable_bit) begin
          control_reg_zero <= pwdata[15:0] & `C0_WMASK;
        end else begin
          control_reg_zero[`C0_ENABLE] <= pwdata[`C0_ENABLE];
        end
      end
      // Start bit self-clears once taken; a new write of one wins
      control_reg_zero[`C0_START] <= (wr_hit[0] & pwdata[`C0_START]) |
        (control_reg_zero[`C0_START] & ~(start_taken & ~pulse_mode_sel) &
         ~(start_taken & pulse_mode_sel));
      if (wr_hit[1] && !conversion_enable_bit) begin
        control_reg_one <= pwdata[15:0] & `C1_WMASK;
      end
      if (wr_hit[2] && !conversion_enable_bit) begin
        control_reg_two <= pwdata[15:0] & `C2_WMASK;
      end
    end
  end

  // Read data prepared in the setup phase, valid in the access phase
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (rd_hit)
        3'h1: prdata <= {16'h0000, control_reg_zero};
        3'h2: prdata <= {16'h0000, ctl_one_rd};
        3'h4: prdata <= {16'h0000, control_reg_two};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // adc_sample_clock_control

// ### verification/adc_ctl_chk.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
`include "adc_ctl_map.vh"
module adc_ctl_chk (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Far side
  input wire timer_trigger_0,
  input wire timer_trigger_1,
  input wire timer_trigger_2,
  input wire module_oscillator_clock,
  input wire sample_control_signal,
  input wire conversion_done,
  input wire converter_busy_flag
);
  reg [15:0] c0;
  reg [15:0] c1;
  reg [13:0] run;
  wire acc = psel && penable;
  wire en = c0[1];
  wire [10:0] c1f = c1[11:1];
  wire [3:0] sht = c0[11:8];
  wire [2:0] trig = {timer_trigger_2, timer_trigger_1, timer_trigger_0};
  wire active = trig[c1[11:10] - 2'h1] ^ c1[8];
  wire [13:0] base = sht < 4'h4 ? 14'h4 << sht : sht > 4'hb ? 14'h400 :
    sht[0] ? 14'h30 << ((sht - 4'h3) >> 1) : 14'h10 << (sht >> 1);
  wire [13:0] want = base * ({11'h0, c1[7:5]} + 14'h1);
  // Shadow of the fields; the enable bit itself never locks
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      c0 <= `C0_RESET;
      c1 <= `C1_RESET;
      run <= 14'h0;
    end else begin
      run <= sample_control_signal ? run + 14'h1 : 14'h0;
      if (acc && pwrite && paddr == `ADDR_CTL_ZERO)
        c0 <= en ? {c0[15:2], pwdata[1], c0[0]} : pwdata[15:0] & `C0_WMASK;
      if (acc && pwrite && paddr == `ADDR_CTL_ONE && !en)
        c1 <= pwdata[15:0] & `C1_WMASK;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_read_one;
    acc && !pwrite && paddr == `ADDR_CTL_ONE;
  endsequence
  sequence s_sample_end;
    $fell(sample_control_signal) && c1[9] && c1[4:3] == 2'h0;
  endsequence
  a_reserved_zero: assert property (s_read_one |-> prdata[31:12] == 20'h0)
    else $error("control one upper bits not zero");
  a_fields_readback: assert property (s_read_one |-> prdata[11:1] == $past(c1f))
    else $error("control one fields wrong");
  a_busy_readback: assert property (s_read_one |-> prdata[0] == $past(converter_busy_flag))
    else $error("busy bit differs from flag");
  a_sample_busy: assert property (sample_control_signal |-> converter_busy_flag)
    else $error("sampling while not busy");
  a_done_single: assert property (conversion_done |=> !conversion_done)
    else $error("done longer than one cycle");
  a_start_enabled: assert property ($rose(converter_busy_flag) |-> $past(en))
    else $error("start while disabled");
  a_direct_fall: assert property (sample_control_signal && !c1[9] && c1[11:10] != 2'h0
    && c1[7:3] == 5'h0 && module_oscillator_clock && !active |=> !sample_control_signal)
    else $error("direct sample outlived its input");
  a_pulse_length: assert property (s_sample_end |-> run == want)
    else $error("sample period length wrong");
endmodule // adc_ctl_chk

bind adc_sample_clock_control adc_ctl_chk i_chk (.clk_sys, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .timer_trigger_0, .timer_trigger_1, .timer_trigger_2,
  .module_oscillator_clock, .sample_control_signal, .conversion_done, .converter_busy_flag);

// ### verification/adc_far_side.sv
// Far side model: timer triggers, converter clock ticks, conversion core
`timescale 1ns/1ps
module adc_far_side (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Timer triggers
  output wire timer_trigger_0,
  output wire timer_trigger_1,
  output wire timer_trigger_2,
  // Ticks and core status
  output wire module_oscillator_clock,
  output wire aux_clock,
  output wire subsystem_master_clock,
  output wire last_channel
);
  reg [2:0] pulse_on = 3'h0;
  reg idle_level = 1'b0;
  reg [2:0] ph;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      ph <= 3'h0;
    else
      ph <= ph == 3'h5 ? 3'h0 : ph + 3'h1;
  end
  // Fast, half and third rate sources to show the divider at three speeds
  assign module_oscillator_clock = 1'b1;
  assign aux_clock = ph[0];
  assign subsystem_master_clock = ph == 3'h2 || ph == 3'h5;
  assign last_channel = 1'b1;
  assign {timer_trigger_2, timer_trigger_1, timer_trigger_0} = {3{idle_level}} ^ pulse_on;
  task pulse(input [1:0] idx, input integer n);
    begin
      @(posedge clk_sys);
      pulse_on[idx - 2'h1] <= 1'b1;
      repeat (n) @(posedge clk_sys);
      pulse_on <= 3'h0;
    end
  endtask
endmodule // adc_far_side

// ### verification/adc_sample_clock_control_bench.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
`include "adc_ctl_map.vh"
module adc_sample_clock_control_bench;
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, timer_trigger_0, timer_trigger_1, timer_trigger_2;
  wire module_oscillator_clock, aux_clock, subsystem_master_clock, last_channel;
  wire sample_control_signal, conversion_done, converter_busy_flag;
  integer mismatches = 0, checks = 0, seed = 32'h32e7, cycles = 0, width = 0;
  integer i, j, n, d, s;
  reg [63:0] rd_e;
  reg [63:0] rd_q[$];
  integer w_q[$];
  adc_sample_clock_control i_dut (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .timer_trigger_0, .timer_trigger_1,
    .timer_trigger_2, .module_oscillator_clock, .aux_clock, .subsystem_master_clock,
    .last_channel, .sample_control_signal, .conversion_done, .converter_busy_flag);
  adc_far_side i_far (.clk_sys, .reset_n, .timer_trigger_0, .timer_trigger_1,
    .timer_trigger_2, .module_oscillator_clock, .aux_clock, .subsystem_master_clock,
    .last_channel);
  always #5 clk_sys = ~clk_sys;
  task check(input string what, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task apb(input [11:0] a, input [31:0] dat, input w);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= dat;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      // Ends once pready reads 1; with no limit of its own, a stuck pready is ended by the bench timeout
      while (pready !== 1'b1)
        @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      rd_q.push_back({m, e});
      apb(a, 32'h0, 1'b0);
    end
  endtask
  // Waits: 0 idle, 1 done pulse, 2 sampling, 3 sampling over
  task wait_until(input [1:0] which);
    integer k;
    begin
      k = 0;
      while ((which == 2'h0 ? !converter_busy_flag : which == 2'h1 ? conversion_done :
          which == 2'h2 ? sample_control_signal : !sample_control_signal) !== 1'b1
          && k < 3000) begin
        k = k + 1;
        @(posedge clk_sys);
      end
      check("wait", 32'h1, {31'h0, k < 3000});
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles > 40000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      rd_e = rd_q.pop_front();
      check("read data", rd_e[31:0], prdata & rd_e[63:32]);
    end
    if (psel && penable && pready)
      check("slave error", {31'h0, paddr > `ADDR_CTL_TWO}, {31'h0, pslverr});
    if (sample_control_signal === 1'b1)
      width = width + 1;
    else if (width > 0) begin
      check("sample length", w_q.size() ? w_q.pop_front() : 0, width);
      width = 0;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`ADDR_CTL_ZERO, ~32'h0, {16'h0, `C0_RESET});
    rd(`ADDR_CTL_ONE, ~32'h0, {16'h0, `C1_RESET});
    rd(`ADDR_CTL_TWO, ~32'h0, {16'h0, `C2_RESET});
    rd(12'h00c, ~32'h0, 32'h0);
    apb(`ADDR_CTL_ONE, ~32'h0, 1'b1);
    rd(`ADDR_CTL_ONE, ~32'h0, 32'h0ffe);
    $display("test reset and reserved done");
    apb(`ADDR_CTL_ONE, 32'h0, 1'b1);
    apb(`ADDR_CTL_ZERO, 32'h0102, 1'b1);
    apb(`ADDR_CTL_ONE, $random(seed), 1'b1);
    rd(`ADDR_CTL_ONE, ~32'h0, 32'h0);
    apb(`ADDR_CTL_ZERO, 32'h0, 1'b1);
    $display("test lock done");
    for (i = 0; i < 8; i = i + 1) begin
      s = i % 4;
      d = $random(seed) & 7;
      n = $random(seed) & 3;
      w_q.push_back((4 << n) * (d + 1) * (s == 0 ? 1 : s == 1 ? 2 : 3));
      apb(`ADDR_CTL_ONE, 32'h200 | d << 5 | s << 3, 1'b1);
      apb(`ADDR_CTL_ZERO, n << 8 | 32'h3, 1'b1);
      wait_until(2'h1);
      wait_until(2'h0);
      apb(`ADDR_CTL_ZERO, 32'h0, 1'b1);
    end
    $display("test divider and source done");
    for (i = 0; i < 4; i = i + 1) begin
      w_q.push_back(4);
      apb(`ADDR_CTL_ONE, 32'h200 | i << 1, 1'b1);
      apb(`ADDR_CTL_ZERO, 32'h3, 1'b1);
      wait_until(2'h1);
      repeat (2) @(posedge clk_sys);
      check("busy after", {31'h0, i[1]}, {31'h0, converter_busy_flag});
      apb(`ADDR_CTL_ZERO, 32'h0, 1'b1);
      wait_until(2'h0);
    end
    // Repeat single with multi-sample: disable lands as the third conversion starts
    for (i = 0; i < 3; i = i + 1)
      w_q.push_back(4);
    apb(`ADDR_CTL_ONE, 32'h204, 1'b1);
    apb(`ADDR_CTL_ZERO, 32'h83, 1'b1);
    wait_until(2'h1);
    @(posedge clk_sys);
    wait_until(2'h1);
    apb(`ADDR_CTL_ZERO, 32'h0, 1'b1);
    wait_until(2'h0);
    check("auto samples", 32'h0, w_q.size());
    $display("test sequence modes done");
    for (i = 1; i < 4; i = i + 1)
      for (j = 0; j < 2; j = j + 1) begin
        i_far.idle_level <= j[0];
        apb(`ADDR_CTL_ONE, i << 10 | j << 8, 1'b1);
        apb(`ADDR_CTL_ZERO, 32'h2, 1'b1);
        n = 3 + ($random(seed) & 7);
        w_q.push_back(n);
        i_far.pulse(i, n);
        wait_until(2'h1);
        apb(`ADDR_CTL_ZERO, 32'h0, 1'b1);
      end
    $display("test trigger select done");
    w_q.push_back(96);
    apb(`ADDR_CTL_ONE, 32'h2f8, 1'b1);
    apb(`ADDR_CTL_ZERO, 32'h3, 1'b1);
    wait_until(2'h2);
    wait_until(2'h3);
    apb(`ADDR_CTL_ZERO, 32'h0, 1'b1);
    n = $random(seed);
    apb(`ADDR_CTL_ONE, n & 32'hfe | 32'h200, 1'b1);
    rd(`ADDR_CTL_ONE, 32'hfffe, n & 32'hfe | 32'h200);
    wait_until(2'h0);
    $display("test change mid conversion done");
    report_and_stop;
  end
endmodule // adc_sample_clock_control_bench
